/* rtl/dcd_pkg.sv */
// shared constants for the configuration and debug register bank
package dcd_pkg;
   localparam int ADDR_W = 12;
   // register byte offsets
   localparam logic [11:0] OFS_DEBUG_STATUS = 12'hD00;
   localparam logic [11:0] OFS_DEBUG_COMMAND = 12'hD04;
   localparam logic [11:0] OFS_DEBUG_INSTRUCTION_LOWER = 12'hD08;
   localparam logic [11:0] OFS_DEBUG_INSTRUCTION_UPPER = 12'hD0C;
   localparam logic [11:0] OFS_BUILD_OPTIONS_WORD = 12'hE00;
   localparam logic [11:0] OFS_INSTRUCTION_CACHE_GEOMETRY = 12'hE04;
   localparam logic [11:0] OFS_STARTUP_FETCH_ADDRESS = 12'hE08;
   // build options word fields
   localparam int BOW_IRQ_LSB = 17;
   localparam int BOW_IRQ_MSB = 21;
   localparam int BOW_PERIPH_LSB = 12;
   localparam int BOW_PERIPH_MSB = 16;
   localparam int BOW_CHAN_LSB = 4;
   localparam int BOW_CHAN_MSB = 6;
   localparam int BOW_MGR_NS_BIT = 2;
   localparam int BOW_START_AT_ADDR_BIT = 1;
   localparam int BOW_PERIPH_PRESENT_BIT = 0;
   // instruction cache geometry fields
   localparam int ICG_LINES_LSB = 4;
   localparam int ICG_LINES_MSB = 7;
   localparam int ICG_LEN_LSB = 0;
   localparam int ICG_LEN_MSB = 2;
   // lower debug instruction fields
   localparam int DIL_BYTES_LSB = 16;
   localparam int DIL_BYTES_MSB = 31;
   localparam int DIL_CHAN_LSB = 8;
   localparam int DIL_CHAN_MSB = 10;
   localparam int DIL_THREAD_BIT = 0;
   // debug command field
   localparam int CMD_LSB = 0;
   localparam int CMD_MSB = 1;
   localparam logic [1:0] CMD_EXECUTE = 2'h0;
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic RST_BIT = 1'b0;
endpackage

/* rtl/dcd_debug_issue.sv */
// debug instruction holding registers, command decode and busy tracking
module dcd_debug_issue (
   input wire logic i_core_clk, // controller clock
   input wire logic i_reset_n, // async reset, active low
   input wire logic i_wr_lower, // write strobe, lower instruction word
   input wire logic i_wr_upper, // write strobe, upper instruction word
   input wire logic i_wr_cmd, // write strobe, debug command
   input wire logic [31:0] i_wdata, // write data
   input wire logic i_done, // engine finished the issued instruction
   output logic o_busy, // debug logic busy
   output logic o_go, // one-cycle issue pulse
   output logic o_thread, // 0 manager thread, 1 channel
   output logic [2:0] o_channel, // selected channel
   output logic [47:0] o_inst // instruction bytes 5..0
);
   logic [31:0] lower_q, lower_d;
   logic [31:0] upper_q, upper_d;
   logic busy_q, busy_d;
   logic go_q, go_d;

   // next values of holding registers and busy flag
   always_comb begin
      lower_d = lower_q;
      upper_d = upper_q;
      busy_d = busy_q;
      go_d = 1'b0;
      if (!busy_q && i_wr_lower) begin
         lower_d = i_wdata;
      end
      if (!busy_q && i_wr_upper) begin
         upper_d = i_wdata;
      end
      if (busy_q && i_done) begin
         busy_d = 1'b0;
      end
      if (!busy_q && i_wr_cmd && i_wdata[dcd_pkg::CMD_MSB:dcd_pkg::CMD_LSB] == dcd_pkg::CMD_EXECUTE) begin
         busy_d = 1'b1;
         go_d = 1'b1;
      end
   end

   // register stage
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lower_q <= dcd_pkg::RST_WORD;
         upper_q <= dcd_pkg::RST_WORD;
         busy_q <= dcd_pkg::RST_BIT;
         go_q <= dcd_pkg::RST_BIT;
      end else begin
         lower_q <= lower_d;
         upper_q <= upper_d;
         busy_q <= busy_d;
         go_q <= go_d;
      end
   end

   // instruction fields toward the engine
   assign o_busy = busy_q;
   assign o_go = go_q;
   assign o_thread = lower_q[dcd_pkg::DIL_THREAD_BIT];
   assign o_channel = lower_q[dcd_pkg::DIL_CHAN_MSB:dcd_pkg::DIL_CHAN_LSB];
   // bytes 5..2 from upper word, bytes 1..0 from lower word
   assign o_inst = {upper_q, lower_q[dcd_pkg::DIL_BYTES_MSB:dcd_pkg::DIL_BYTES_LSB]};
endmodule

/* rtl/dcd_regs.sv */
// configuration and debug register bank behind the apb register port
module dcd_regs (
   input wire logic i_core_clk, // controller clock
   input wire logic i_reset_n, // async reset, active low
   input wire logic i_psel, // apb select
   input wire logic i_penable, // apb enable
   input wire logic i_pwrite, // apb write
   input wire logic [11:0] i_paddr, // apb byte address
   input wire logic [31:0] i_pwdata, // apb write data
   output logic [31:0] o_prdata, // apb read data
   output logic o_pready, // apb ready
   output logic o_pslverr, // apb error on unmapped address
   input wire logic [2:0] i_chan_count_m1, // channels minus one tie-off
   input wire logic i_periph_present, // peripheral interfaces exist tie-off
   input wire logic [4:0] i_periph_count_m1, // peripheral interfaces minus one tie-off
   input wire logic [4:0] i_irq_count_m1, // interrupt outputs minus one tie-off
   input wire logic i_manager_nonsecure_tie, // manager non-secure strap
   input wire logic i_start_at_address_tie, // start from boot address strap
   input wire logic [3:0] i_icache_lines_m1, // cache lines minus one tie-off
   input wire logic [2:0] i_icache_len, // cache line length code tie-off
   input wire logic [31:0] i_boot_addr, // boot address tie-off
   input wire logic i_dbg_done, // engine finished debug instruction
   output logic o_dbg_go, // one-cycle debug issue pulse
   output logic o_dbg_thread, // debug thread select
   output logic [2:0] o_dbg_channel, // debug channel
   output logic [47:0] o_dbg_inst // debug instruction bytes 5..0
);
   // captured configuration words
   logic captured_q, captured_d;
   logic [31:0] build_q, build_d;
   logic [31:0] geom_q, geom_d;
   logic [31:0] fetch_q, fetch_d;
   // bus answer and decode
   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d;
   logic pready_q;
   logic setup;
   logic wr_access;
   logic wr_lower, wr_upper, wr_cmd;
   logic dbg_busy;
   // straps as seen at the pins and after two flops
   localparam int TIE_W = 55;
   logic [TIE_W-1:0] tie_raw;
   logic [TIE_W-1:0] tie_meta_q;
   logic [TIE_W-1:0] tie_sync_q;
   // synchronised strap fields
   logic [4:0] irq_count_s;
   logic [4:0] periph_count_s;
   logic [2:0] chan_count_s;
   logic periph_present_s;
   logic manager_nonsecure_s;
   logic start_at_address_s;
   logic [3:0] icache_lines_s;
   logic [2:0] icache_len_s;
   logic [31:0] boot_addr_s;

   // apb phase decode
   assign setup = i_psel && !i_penable;
   assign wr_access = i_psel && i_penable && i_pwrite;

   // write strobes; configuration words take no write
   always_comb begin
      wr_lower = 1'b0;
      wr_upper = 1'b0;
      wr_cmd = 1'b0;
      if (wr_access && i_paddr == dcd_pkg::OFS_DEBUG_INSTRUCTION_LOWER) begin
         wr_lower = 1'b1;
      end else if (wr_access && i_paddr == dcd_pkg::OFS_DEBUG_INSTRUCTION_UPPER) begin
         wr_upper = 1'b1;
      end else if (wr_access && i_paddr == dcd_pkg::OFS_DEBUG_COMMAND) begin
         wr_cmd = 1'b1;
      end
   end

   // straps packed into one vector for the synchroniser
   assign tie_raw = {
      i_irq_count_m1,
      i_periph_count_m1,
      i_chan_count_m1,
      i_periph_present,
      i_manager_nonsecure_tie,
      i_start_at_address_tie,
      i_icache_lines_m1,
      i_icache_len,
      i_boot_addr
   };

   // two flops with no reset, so they fill while reset is held
   // straps must stand still for two edges before reset release
   always_ff @(posedge i_core_clk) begin
      tie_meta_q <= tie_raw;
      tie_sync_q <= tie_meta_q;
   end

   // synchronised straps split back into fields
   assign {
      irq_count_s,
      periph_count_s,
      chan_count_s,
      periph_present_s,
      manager_nonsecure_s,
      start_at_address_s,
      icache_lines_s,
      icache_len_s,
      boot_addr_s
   } = tie_sync_q;

   // tie-off capture on first edge after reset release
   always_comb begin
      captured_d = 1'b1;
      build_d = build_q;
      geom_d = geom_q;
      fetch_d = fetch_q;
      if (!captured_q) begin
         build_d = dcd_pkg::RST_WORD; // reserved bits read zero
         build_d[dcd_pkg::BOW_IRQ_MSB:dcd_pkg::BOW_IRQ_LSB] = irq_count_s;
         build_d[dcd_pkg::BOW_PERIPH_MSB:dcd_pkg::BOW_PERIPH_LSB] = periph_count_s;
         build_d[dcd_pkg::BOW_CHAN_MSB:dcd_pkg::BOW_CHAN_LSB] = chan_count_s;
         build_d[dcd_pkg::BOW_MGR_NS_BIT] = manager_nonsecure_s;
         build_d[dcd_pkg::BOW_START_AT_ADDR_BIT] = start_at_address_s;
         build_d[dcd_pkg::BOW_PERIPH_PRESENT_BIT] = periph_present_s;
         geom_d = dcd_pkg::RST_WORD;
         geom_d[dcd_pkg::ICG_LINES_MSB:dcd_pkg::ICG_LINES_LSB] = icache_lines_s;
         geom_d[dcd_pkg::ICG_LEN_MSB:dcd_pkg::ICG_LEN_LSB] = icache_len_s;
         fetch_d = boot_addr_s;
      end
   end

   // capture registers, held until next reset
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         captured_q <= dcd_pkg::RST_BIT;
         build_q <= dcd_pkg::RST_WORD;
         geom_q <= dcd_pkg::RST_WORD;
         fetch_q <= dcd_pkg::RST_WORD;
      end else begin
         captured_q <= captured_d;
         build_q <= build_d;
         geom_q <= geom_d;
         fetch_q <= fetch_d;
      end
   end

   // read data and error chosen in setup phase, shown in access phase
   always_comb begin
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      if (setup) begin
         prdata_d = dcd_pkg::RST_WORD;
         if (i_paddr == dcd_pkg::OFS_DEBUG_STATUS) begin
            prdata_d[0] = dbg_busy;
         end else if (i_paddr == dcd_pkg::OFS_BUILD_OPTIONS_WORD) begin
            prdata_d = build_q;
         end else if (i_paddr == dcd_pkg::OFS_INSTRUCTION_CACHE_GEOMETRY) begin
            prdata_d = geom_q;
         end else if (i_paddr == dcd_pkg::OFS_STARTUP_FETCH_ADDRESS) begin
            prdata_d = fetch_q;
         end else if (i_paddr == dcd_pkg::OFS_DEBUG_COMMAND
                      || i_paddr == dcd_pkg::OFS_DEBUG_INSTRUCTION_LOWER
                      || i_paddr == dcd_pkg::OFS_DEBUG_INSTRUCTION_UPPER) begin
            prdata_d = dcd_pkg::RST_WORD; // write-only, reads zero
         end else begin
            // unmapped address answers with an error
            pslverr_d = 1'b1;
         end
      end else if (i_psel && i_penable) begin
         pslverr_d = pslverr_q; // hold through access phase
      end
   end

   // bus answer registers
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prdata_q <= dcd_pkg::RST_WORD;
         pslverr_q <= dcd_pkg::RST_BIT;
         pready_q <= dcd_pkg::RST_BIT;
      end else begin
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
         pready_q <= 1'b1;
      end
   end

   // bus outputs straight from their flops
   assign o_prdata = prdata_q;
   assign o_pslverr = pslverr_q;
   assign o_pready = pready_q;

   // debug issue unit
   dcd_debug_issue u_issue (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_wr_lower(wr_lower),
      .i_wr_upper(wr_upper),
      .i_wr_cmd(wr_cmd),
      .i_wdata(i_pwdata),
      .i_done(i_dbg_done),
      .o_busy(dbg_busy),
      .o_go(o_dbg_go),
      .o_thread(o_dbg_thread),
      .o_channel(o_dbg_channel),
      .o_inst(o_dbg_inst)
   );
endmodule

/* test/dcd_regs_asserts.sv */
// port assertions for the configuration and debug register bank
module dcd_regs_asserts (
   input wire logic i_core_clk, // clock
   input wire logic i_reset_n, // reset
   input wire logic i_psel, // select
   input wire logic i_penable, // enable
   input wire logic i_pwrite, // write
   input wire logic [11:0] i_paddr, // address
   input wire logic [31:0] i_pwdata, // wdata
   input wire logic [31:0] o_prdata, // rdata
   input wire logic [2:0] i_chan_count_m1, // tie
   input wire logic i_periph_present, // tie
   input wire logic [4:0] i_periph_count_m1, // tie
   input wire logic [4:0] i_irq_count_m1, // tie
   input wire logic i_manager_nonsecure_tie, // tie
   input wire logic i_start_at_address_tie, // tie
   input wire logic [3:0] i_icache_lines_m1, // tie
   input wire logic [2:0] i_icache_len, // tie
   input wire logic [31:0] i_boot_addr, // tie
   input wire logic i_dbg_done, // done
   input wire logic o_dbg_go, // go
   input wire logic [47:0] o_dbg_inst // inst
);
   timeunit 1ns;
   timeprecision 100ps;
   logic cap_q, busy_q;
   logic [21:0] bow_q;
   logic [7:0] icg_q;
   logic [31:0] sfa_q, up_q, lo_q;
   wire wr = i_psel && i_penable && i_pwrite;
   wire busy = busy_q || o_dbg_go;
   wire ex = wr && i_paddr == dcd_pkg::OFS_DEBUG_COMMAND && i_pwdata[1:0] == 2'h0;
   // ties seen at release, busy and held words
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cap_q <= 1'b1;
         busy_q <= 1'b0;
      end else begin
         cap_q <= 1'b0;
         busy_q <= busy && !i_dbg_done;
         if (cap_q) begin
            bow_q <= {i_irq_count_m1, i_periph_count_m1, 5'h00, i_chan_count_m1, 1'b0,
               i_manager_nonsecure_tie, i_start_at_address_tie, i_periph_present};
            icg_q <= {i_icache_lines_m1, 1'b0, i_icache_len};
            sfa_q <= i_boot_addr;
         end
         if (wr && !busy && i_paddr == dcd_pkg::OFS_DEBUG_INSTRUCTION_LOWER) lo_q <= i_pwdata;
         if (wr && !busy && i_paddr == dcd_pkg::OFS_DEBUG_INSTRUCTION_UPPER) up_q <= i_pwdata;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_rd(logic [11:0] a);
      i_psel && !i_penable && !i_pwrite && i_paddr == a;
   endsequence
   sequence s_pulse;
      o_dbg_go ##1 !o_dbg_go;
   endsequence
   property p_bow;
      s_rd(dcd_pkg::OFS_BUILD_OPTIONS_WORD) |=> o_prdata[21:0] == bow_q;
   endproperty
   a_bow: assert property (p_bow) else $error("build word");
   property p_icg;
      s_rd(dcd_pkg::OFS_INSTRUCTION_CACHE_GEOMETRY) |=> o_prdata[7:0] == icg_q;
   endproperty
   a_icg: assert property (p_icg) else $error("cache geometry");
   property p_sfa;
      s_rd(dcd_pkg::OFS_STARTUP_FETCH_ADDRESS) |=> o_prdata == sfa_q;
   endproperty
   a_sfa: assert property (p_sfa) else $error("boot address");
   property p_issue;
      ex && !busy |=> s_pulse;
   endproperty
   a_issue: assert property (p_issue) else $error("no issue pulse");
   property p_cause;
      o_dbg_go |-> $past(ex);
   endproperty
   a_cause: assert property (p_cause) else $error("stray issue");
   property p_refuse;
      ex && busy_q |=> !o_dbg_go;
   endproperty
   a_refuse: assert property (p_refuse) else $error("issue while busy");
   property p_inst;
      o_dbg_go |-> o_dbg_inst == {up_q, lo_q[31:16]};
   endproperty
   a_inst: assert property (p_inst) else $error("instruction bytes");
   property p_busy;
      s_rd(dcd_pkg::OFS_DEBUG_STATUS) |=> o_prdata[0] == $past(busy);
   endproperty
   a_busy: assert property (p_busy) else $error("status bit");
endmodule

/* test/testbench.sv */
// self-checking bench for the register bank
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, i_boot_addr = 32'h0, o_prdata, rd, lo, up;
   logic o_pready, o_pslverr, o_dbg_go, o_dbg_thread, err, i_dbg_done = 1'b0;
   logic [2:0] i_chan_count_m1 = 3'h0, i_icache_len = 3'h0, o_dbg_channel;
   logic [4:0] i_periph_count_m1 = 5'h00, i_irq_count_m1 = 5'h00;
   logic [3:0] i_icache_lines_m1 = 4'h0;
   logic i_periph_present = 1'b0, i_manager_nonsecure_tie = 1'b0, i_start_at_address_tie = 1'b0;
   logic [47:0] o_dbg_inst;
   logic [31:0] ex [3];
   int seed = 7815, miscompares = 0, n_compared = 0, n_go = 0;
   dcd_regs i_dcd_regs (.*);
   // clock and issue pulse count
   always #12.5 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) if (o_dbg_go === 1'b1) n_go <= n_go + 1;
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // one transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(negedge i_core_clk);
      i_psel = 1'b1;
      i_pwrite = w;
      i_paddr = a;
      i_pwdata = d;
      @(negedge i_core_clk);
      i_penable = 1'b1;
      for (n = 0; n < 8; n++) begin
         @(posedge i_core_clk);
         if (o_pready === 1'b1) break;
      end
      rd = o_prdata;
      err = o_pslverr;
      if (n == 8) begin
         miscompares++;
         conclude();
      end
      @(negedge i_core_clk);
      i_psel = 1'b0;
      i_penable = 1'b0;
   endtask
   // expected build options word from the ties
   function automatic logic [31:0] exp_bow();
      return {10'h000, i_irq_count_m1, i_periph_count_m1, 5'h00, i_chan_count_m1, 1'b0,
         i_manager_nonsecure_tie, i_start_at_address_tie, i_periph_present};
   endfunction
   // random ties, corners at both ends, twenty reset cycles
   task automatic restart(input int r);
      logic [63:0] v;
      i_reset_n = 1'b0;
      v = {$random(seed), $random(seed)};
      if (r == 0) v = '0;
      if (r == 7) v = '1;
      {i_boot_addr, i_irq_count_m1, i_periph_count_m1, i_chan_count_m1, i_periph_present,
         i_manager_nonsecure_tie, i_start_at_address_tie, i_icache_lines_m1} = v[51:0];
      i_icache_len = r[2:0];
      repeat (20) @(negedge i_core_clk);
      i_reset_n = 1'b1;
   endtask
   // main sequence
   initial begin
      for (int r = 0; r < 8; r++) begin
         restart(r);
         ex[0] = exp_bow();
         ex[1] = {24'h000000, i_icache_lines_m1, 1'b0, i_icache_len};
         ex[2] = i_boot_addr;
         for (int k = 0; k < 6; k++) begin
            apb(k > 2, dcd_pkg::OFS_BUILD_OPTIONS_WORD + 12'(4 * (k % 3)), $random(seed));
            if (k < 3) check(rd, ex[k]);
            if (k == 0) check(rd[16:12] & {5{rd[0]}}, ex[0][16:12] & {5{ex[0][0]}});
         end
         {i_irq_count_m1, i_chan_count_m1, i_icache_len, i_boot_addr} =
            ~{ex[0][21:17], ex[0][6:4], ex[1][2:0], ex[2]};
         for (int k = 0; k < 3; k++) begin
            apb(1'b0, dcd_pkg::OFS_BUILD_OPTIONS_WORD + 12'(4 * k), 32'h0);
            check(rd, ex[k]);
         end
      end
      apb(1'b0, 12'h004, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
      lo = $random(seed);
      up = $random(seed);
      apb(1'b1, dcd_pkg::OFS_DEBUG_INSTRUCTION_LOWER, lo);
      apb(1'b1, dcd_pkg::OFS_DEBUG_INSTRUCTION_UPPER, up);
      for (int c = 3; c >= 0; c--) begin
         apb(1'b1, dcd_pkg::OFS_DEBUG_COMMAND, 32'(c));
         apb(1'b0, dcd_pkg::OFS_DEBUG_STATUS, 32'h0);
         check(rd[0], c == 0);
      end
      apb(1'b1, dcd_pkg::OFS_DEBUG_INSTRUCTION_LOWER, ~lo);
      apb(1'b1, dcd_pkg::OFS_DEBUG_INSTRUCTION_UPPER, ~up);
      apb(1'b1, dcd_pkg::OFS_DEBUG_COMMAND, 32'h0);
      @(negedge i_core_clk);
      i_dbg_done = 1'b1;
      @(negedge i_core_clk);
      i_dbg_done = 1'b0;
      apb(1'b0, dcd_pkg::OFS_DEBUG_STATUS, 32'h0);
      check(rd[0], 1'b0);
      check(o_dbg_inst, {up, lo[31:16]});
      check({o_dbg_thread, o_dbg_channel}, {lo[0], lo[10:8]});
      check(n_go, 1);
      conclude();
   end
endmodule
bind dcd_regs dcd_regs_asserts i_dcd_regs_asserts (.*);
